// ---- rtl/i2c_bus_start_stop_control.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Option clear: enabling sets bus busy
// - Option set: enabling clears bus busy
// - No master start while bus unreleased
// - Enable with clock high and data low counts as start
// - Reserved transfer starts on shift write
// - Reserved start waits without an interrupt
// - Reserved start follows detected stop
// - Start request on free bus starts
module i2c_bus_start_stop_control (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link clock for bus condition detection
  input wire logic clk_link_i,
  // Configuration levels
  input wire logic controller_enable_i,
  input wire logic initial_start_enable_i,
  input wire logic reservation_disable_i,
  input wire logic stop_interrupt_enable_i,
  input wire logic [7:0] low_width_i,
  input wire logic [7:0] high_width_i,
  input wire logic [6:0] own_slave_address_i,
  // Software strobes, one cycle each
  input wire logic start_trigger_i,
  input wire logic stop_trigger_i,
  input wire logic exit_communication_i,
  input wire logic shift_write_i,
  input wire logic [7:0] shift_data_i,
  // Open-drain lines
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  // Status
  output logic bus_busy_flag_o,
  output logic master_status_flag_o,
  output logic start_rejected_flag_o,
  output logic reservation_pending_o,
  output logic acknowledge_detected_o,
  output logic extension_code_flag_o,
  output logic address_match_flag_o,
  output logic clock_level_flag_o,
  output logic data_level_flag_o,
  output logic [7:0] received_byte_o,
  output logic serial_interrupt_o
);

  i2c_ctl_pkg::ctl_state_type state_q;
  i2c_ctl_pkg::pin_drive_type drive_q;
  i2c_ctl_pkg::bus_event_type ev;
  logic start_tgl;
  logic stop_tgl;
  logic byte_tgl;
  logic [7:0] link_byte;
  logic [2:0] start_sync_q;
  logic [2:0] stop_sync_q;
  logic [2:0] byte_sync_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic en_q;
  logic en_rise;
  logic [7:0] timer_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic listen_q;
  logic ack_drive_q;
  logic ack_scl_high_q;
  logic ack_low_q;
  logic timer_done;
  logic start_now;

  function automatic logic is_ext_code(input logic [7:0] b);
    return b[7:3] == i2c_ctl_pkg::EXT_CODE_PREFIX;
  endfunction : is_ext_code

  bus_condition_detect u_detect (
    .clk_link_i(clk_link_i),
    .rst_i(rst_i),
    .scl_pin_i(serial_clock_pin_i),
    .sda_pin_i(serial_data_pin_i),
    .enable_i(en_q),
    .start_tgl_o(start_tgl),
    .stop_tgl_o(stop_tgl),
    .byte_tgl_o(byte_tgl),
    .byte_o(link_byte)
  );

  // Toggle crossings; edge taken between the second and third stage
  always_ff @(posedge clk_sys_i) begin
    start_sync_q <= {start_sync_q[1:0], start_tgl};
    stop_sync_q <= {stop_sync_q[1:0], stop_tgl};
    byte_sync_q <= {byte_sync_q[1:0], byte_tgl};
    scl_sync_q <= {scl_sync_q[0], serial_clock_pin_i};
    sda_sync_q <= {sda_sync_q[0], serial_data_pin_i};
  end

  always_comb begin
    ev.start = start_sync_q[2] ^ start_sync_q[1];
    ev.stop = stop_sync_q[2] ^ stop_sync_q[1];
    ev.byte_done = byte_sync_q[2] ^ byte_sync_q[1];
  end

  assign en_rise = controller_enable_i & ~en_q;
  assign timer_done = timer_q == i2c_ctl_pkg::TIMER_ZERO;
  assign start_now = state_q == i2c_ctl_pkg::ST_IDLE && en_q &&
    ((start_trigger_i && !bus_busy_flag_o) ||
     (reservation_pending_o && ev.stop));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      clock_level_flag_o <= 1'b1;
      data_level_flag_o <= 1'b1;
      serial_clock_pin_o <= 1'b0;
      serial_data_pin_o <= 1'b0;
    end else begin
      en_q <= controller_enable_i;
      clock_level_flag_o <= scl_sync_q[1];
      data_level_flag_o <= sda_sync_q[1];
      serial_clock_pin_o <= 1'b0;
      serial_data_pin_o <= 1'b0;
    end
  end

  // Busy tracking; a start event wins over a stop in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !controller_enable_i) begin
      bus_busy_flag_o <= 1'b0;
    end else if (en_rise) begin
      bus_busy_flag_o <= ~initial_start_enable_i;
    end else if (ev.start) begin
      bus_busy_flag_o <= 1'b1;
    end else if (ev.stop) begin
      bus_busy_flag_o <= 1'b0;
    end
  end

  // Start requests on a busy bus become reservations or are refused
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !en_q) begin
      reservation_pending_o <= 1'b0;
      start_rejected_flag_o <= 1'b0;
    end else begin
      if (start_trigger_i && bus_busy_flag_o &&
          state_q == i2c_ctl_pkg::ST_IDLE) begin
        reservation_pending_o <= ~reservation_disable_i;
        start_rejected_flag_o <= reservation_disable_i;
      end else if (start_now) begin
        reservation_pending_o <= 1'b0;
        start_rejected_flag_o <= 1'b0;
      end
    end
  end

  // Slave listening with acknowledge for address or extension code
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !en_q) begin
      listen_q <= 1'b0;
      ack_drive_q <= 1'b0;
      ack_scl_high_q <= 1'b0;
      ack_low_q <= 1'b0;
      extension_code_flag_o <= 1'b0;
      address_match_flag_o <= 1'b0;
      received_byte_o <= i2c_ctl_pkg::BYTE_RESET;
    end else if (exit_communication_i || ev.stop) begin
      listen_q <= 1'b0;
      ack_drive_q <= 1'b0;
      extension_code_flag_o <= 1'b0;
      address_match_flag_o <= 1'b0;
    end else if (ev.start) begin
      listen_q <= ~master_status_flag_o;
      ack_drive_q <= 1'b0;
      extension_code_flag_o <= 1'b0;
      address_match_flag_o <= 1'b0;
    end else if (ev.byte_done && listen_q) begin
      received_byte_o <= link_byte;
      listen_q <= 1'b0;
      extension_code_flag_o <= is_ext_code(link_byte);
      address_match_flag_o <= link_byte[7:1] == own_slave_address_i;
      ack_drive_q <= is_ext_code(link_byte) ||
        link_byte[7:1] == own_slave_address_i;
      ack_scl_high_q <= 1'b0;
      ack_low_q <= 1'b0;
    end else if (ack_drive_q) begin
      // Pull only once the clock is low: pulling data under a high clock
      // would put a false start on the bus
      if (!ack_low_q) begin
        if (!scl_sync_q[1]) begin
          ack_low_q <= 1'b1;
        end
      end else if (scl_sync_q[1]) begin
        ack_scl_high_q <= 1'b1;
      end else if (ack_scl_high_q) begin
        ack_drive_q <= 1'b0;
      end
    end
  end

  // Master sequencer and line drive
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !en_q) begin
      state_q <= i2c_ctl_pkg::ST_IDLE;
      drive_q <= '0;
      timer_q <= i2c_ctl_pkg::TIMER_ZERO;
      bit_q <= i2c_ctl_pkg::BIT_ZERO;
      shift_q <= i2c_ctl_pkg::BYTE_RESET;
      master_status_flag_o <= 1'b0;
      acknowledge_detected_o <= 1'b0;
    end else begin
      if (!timer_done) begin
        timer_q <= timer_q - 8'h01;
      end
      case (state_q)
        i2c_ctl_pkg::ST_IDLE: begin
          drive_q.scl_oe <= 1'b0;
          drive_q.sda_oe <= 1'b0;
          if (start_now) begin
            drive_q.sda_oe <= 1'b1;
            master_status_flag_o <= 1'b1;
            timer_q <= high_width_i;
            state_q <= i2c_ctl_pkg::ST_START_HI;
          end else if (stop_trigger_i) begin
            drive_q <= '{scl_oe: 1'b1, sda_oe: 1'b1};
            timer_q <= low_width_i;
            state_q <= i2c_ctl_pkg::ST_STOP_LO;
          end
        end
        i2c_ctl_pkg::ST_START_HI: begin
          if (timer_done) begin
            drive_q.scl_oe <= 1'b1;
            state_q <= i2c_ctl_pkg::ST_WAIT;
          end
        end
        i2c_ctl_pkg::ST_WAIT: begin
          // Clock held low until software acts
          if (shift_write_i) begin
            shift_q <= shift_data_i;
            bit_q <= i2c_ctl_pkg::BIT_ZERO;
            drive_q.sda_oe <= ~shift_data_i[7];
            timer_q <= low_width_i;
            state_q <= i2c_ctl_pkg::ST_BIT_LO;
          end else if (stop_trigger_i) begin
            drive_q.sda_oe <= 1'b1;
            timer_q <= low_width_i;
            state_q <= i2c_ctl_pkg::ST_STOP_LO;
          end else if (start_trigger_i) begin
            drive_q <= '0;
            timer_q <= high_width_i;
            state_q <= i2c_ctl_pkg::ST_RS_HI;
          end
        end
        i2c_ctl_pkg::ST_BIT_LO: begin
          if (timer_done) begin
            drive_q.scl_oe <= 1'b0;
            timer_q <= high_width_i;
            state_q <= i2c_ctl_pkg::ST_BIT_HI;
          end
        end
        i2c_ctl_pkg::ST_BIT_HI: begin
          // Counts only once the clock is really high: slaves may stretch
          if (!scl_sync_q[1]) begin
            timer_q <= high_width_i;
          end else if (timer_done) begin
            drive_q.scl_oe <= 1'b1;
            timer_q <= low_width_i;
            if (bit_q == i2c_ctl_pkg::BIT_ACK) begin
              acknowledge_detected_o <= ~sda_sync_q[1];
              drive_q.sda_oe <= 1'b0;
              state_q <= i2c_ctl_pkg::ST_WAIT;
            end else begin
              bit_q <= bit_q + 4'h1;
              shift_q <= {shift_q[6:0], 1'b0};
              // Released for the acknowledge bit
              drive_q.sda_oe <= (bit_q == i2c_ctl_pkg::BIT_LAST_DATA) ?
                1'b0 : ~shift_q[6];
              state_q <= i2c_ctl_pkg::ST_BIT_LO;
            end
          end
        end
        i2c_ctl_pkg::ST_STOP_LO: begin
          if (timer_done) begin
            drive_q.scl_oe <= 1'b0;
            timer_q <= high_width_i;
            state_q <= i2c_ctl_pkg::ST_STOP_HI;
          end
        end
        i2c_ctl_pkg::ST_STOP_HI: begin
          if (timer_done && scl_sync_q[1]) begin
            drive_q.sda_oe <= 1'b0;
            timer_q <= low_width_i;
            state_q <= i2c_ctl_pkg::ST_STOP_END;
          end
        end
        i2c_ctl_pkg::ST_STOP_END: begin
          master_status_flag_o <= 1'b0;
          if (timer_done) begin
            state_q <= i2c_ctl_pkg::ST_IDLE;
          end
        end
        i2c_ctl_pkg::ST_RS_HI: begin
          if (timer_done && scl_sync_q[1]) begin
            drive_q.sda_oe <= 1'b1;
            timer_q <= high_width_i;
            state_q <= i2c_ctl_pkg::ST_START_HI;
          end
        end
        default: begin
          state_q <= i2c_ctl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Outputs from flops; interrupt on stop (if enabled) and byte end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      serial_clock_pin_oe_o <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
      serial_interrupt_o <= 1'b0;
    end else begin
      serial_clock_pin_oe_o <= drive_q.scl_oe;
      serial_data_pin_oe_o <= drive_q.sda_oe | (ack_drive_q & ack_low_q);
      serial_interrupt_o <= (ev.stop & stop_interrupt_enable_i) |
        (state_q == i2c_ctl_pkg::ST_BIT_HI && scl_sync_q[1] &&
         timer_done && bit_q == i2c_ctl_pkg::BIT_ACK) |
        (ev.byte_done & listen_q);
    end
  end

endmodule : i2c_bus_start_stop_control

// ---- pkg/i2c_ctl_pkg.sv ----
package i2c_ctl_pkg;

  // Controller sequencing states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_START_HI = 9'h002,
    ST_WAIT     = 9'h004,
    ST_BIT_LO   = 9'h008,
    ST_BIT_HI   = 9'h010,
    ST_STOP_LO  = 9'h020,
    ST_STOP_HI  = 9'h040,
    ST_STOP_END = 9'h080,
    ST_RS_HI    = 9'h100
  } ctl_state_type;

  // Drive of the two open-drain lines; a set enable pulls the line low
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } pin_drive_type;

  // Bus events as seen in the system domain, one-cycle pulses
  typedef struct packed {
    logic start;
    logic stop;
    logic byte_done;
  } bus_event_type;

  localparam logic [7:0] TIMER_ZERO = 8'h00;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  // Eight data bits then the acknowledge bit
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  // General-call style extension codes carry this in the top five bits
  localparam logic [4:0] EXT_CODE_PREFIX = 5'h1E;
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : i2c_ctl_pkg

// ---- rtl/bus_condition_detect.sv ----
`timescale 1ns/1ps
// Link-side watcher: start, stop and received bytes, reported by toggles
module bus_condition_detect (
  // Link clock
  input wire logic clk_link_i,
  input wire logic rst_i,
  // Raw pins and enable from the system domain
  input wire logic scl_pin_i,
  input wire logic sda_pin_i,
  input wire logic enable_i,
  // Event toggles and captured byte
  output logic start_tgl_o,
  output logic stop_tgl_o,
  output logic byte_tgl_o,
  output logic [7:0] byte_o
);

  logic [1:0] rst_sync_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] en_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic en_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic link_rst;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;

  always_ff @(posedge clk_link_i) begin
    rst_sync_q <= {rst_sync_q[0], rst_i};
    scl_sync_q <= {scl_sync_q[0], scl_pin_i};
    sda_sync_q <= {sda_sync_q[0], sda_pin_i};
    en_sync_q <= {en_sync_q[0], enable_i};
  end

  assign link_rst = rst_sync_q[1];
  assign scl_rise = scl_sync_q[1] & ~scl_prev_q;

  always_comb begin
    start_seen = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    if (en_sync_q[1] && !en_prev_q && scl_sync_q[1] && !sda_sync_q[1]) begin
      start_seen = 1'b1;
    end
    stop_seen = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      en_prev_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
      en_prev_q <= en_sync_q[1];
    end
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      start_tgl_o <= 1'b0;
      stop_tgl_o <= 1'b0;
    end else begin
      if (start_seen) begin
        start_tgl_o <= ~start_tgl_o;
      end
      if (stop_seen) begin
        stop_tgl_o <= ~stop_tgl_o;
      end
    end
  end

  // Byte stays stable until the next eight bits, long after the toggle
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      bit_cnt_q <= i2c_ctl_pkg::BIT_ZERO;
      shift_q <= i2c_ctl_pkg::BYTE_RESET;
      byte_o <= i2c_ctl_pkg::BYTE_RESET;
      byte_tgl_o <= 1'b0;
    end else if (start_seen || stop_seen) begin
      bit_cnt_q <= i2c_ctl_pkg::BIT_ZERO;
    end else if (scl_rise) begin
      if (bit_cnt_q == i2c_ctl_pkg::BIT_ACK) begin
        bit_cnt_q <= i2c_ctl_pkg::BIT_ZERO;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q <= {shift_q[6:0], sda_sync_q[1]};
        if (bit_cnt_q == i2c_ctl_pkg::BIT_LAST_DATA) begin
          byte_o <= {shift_q[6:0], sda_sync_q[1]};
          byte_tgl_o <= ~byte_tgl_o;
        end
      end
    end
  end

endmodule : bus_condition_detect

// ---- testbench/i2c_ctl_checker.sv ----
`timescale 1ns/1ps
module i2c_ctl_checker (
  // Clock, reset and controls
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic controller_enable_i,
  input wire logic initial_start_enable_i,
  input wire logic reservation_disable_i,
  input wire logic stop_interrupt_enable_i,
  input wire logic start_trigger_i,
  input wire logic shift_write_i,
  // Watched outputs
  input wire logic serial_clock_pin_oe_o,
  input wire logic serial_data_pin_oe_o,
  input wire logic bus_busy_flag_o,
  input wire logic master_status_flag_o,
  input wire logic start_rejected_flag_o,
  input wire logic reservation_pending_o,
  input wire logic serial_interrupt_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic en_q;
  logic idle_w;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) en_q <= 1'b0;
    else en_q <= controller_enable_i;
  end
  // Triggers count only once the enable has settled for an edge
  assign idle_w = controller_enable_i && en_q && !master_status_flag_o
    && !serial_data_pin_oe_o && !serial_clock_pin_oe_o;
  sequence seize_s;
    ##[1:3] serial_data_pin_oe_o && !serial_clock_pin_oe_o
      && master_status_flag_o;
  endsequence
  sequence hold_s;
    serial_clock_pin_oe_o [*4];
  endsequence
  busy_on_enable_a : assert property (
    $rose(controller_enable_i) && !initial_start_enable_i
      |-> ##[1:3] bus_busy_flag_o)
    else $error("bus busy not set on enable");
  idle_on_enable_a : assert property (
    $rose(controller_enable_i) && initial_start_enable_i
      |-> ##[1:3] !bus_busy_flag_o)
    else $error("bus busy not clear on enable");
  start_refused_a : assert property (
    start_trigger_i && idle_w && bus_busy_flag_o && reservation_disable_i
      |-> ##[1:2] start_rejected_flag_o && !master_status_flag_o)
    else $error("start on busy bus not refused");
  reserve_set_a : assert property (
    start_trigger_i && idle_w && bus_busy_flag_o && !reservation_disable_i
      |-> ##[1:2] reservation_pending_o && !serial_data_pin_oe_o)
    else $error("reservation not taken");
  free_start_a : assert property (
    start_trigger_i && idle_w && !bus_busy_flag_o && !reservation_pending_o
      |-> seize_s ##[1:300] hold_s)
    else $error("start on free bus not made");
  reserved_start_a : assert property (
    $fell(bus_busy_flag_o) && $past(reservation_pending_o) && en_q
      && controller_enable_i |-> ##[0:4] seize_s ##[1:300] hold_s)
    else $error("reserved start missing");
  stop_irq_a : assert property (
    $fell(bus_busy_flag_o) && stop_interrupt_enable_i && en_q
      && controller_enable_i |-> ##[0:3] serial_interrupt_o)
    else $error("stop interrupt missing");
  shift_go_a : assert property (
    shift_write_i && master_status_flag_o && serial_clock_pin_oe_o
      |-> ##[1:300] !serial_clock_pin_oe_o)
    else $error("shift write did not start transfer");
endmodule : i2c_ctl_checker

bind i2c_bus_start_stop_control i2c_ctl_checker chk (
  .clk_sys_i, .rst_i, .controller_enable_i, .initial_start_enable_i,
  .reservation_disable_i, .stop_interrupt_enable_i, .start_trigger_i,
  .shift_write_i, .serial_clock_pin_oe_o, .serial_data_pin_oe_o,
  .bus_busy_flag_o, .master_status_flag_o, .start_rejected_flag_o,
  .reservation_pending_o, .serial_interrupt_o);

// ---- testbench/bus_partner.sv ----
`timescale 1ns/1ps
module bus_partner (
  // Clock and resolved lines
  input wire logic clk_sys_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  // Pull-low enables
  output logic scl_oe_o,
  output logic sda_oe_o
);
  logic scl_q = 1'b0;
  logic sda_q = 1'b0;
  logic ack_q = 1'b0;
  int falls = 0;
  assign scl_oe_o = scl_q;
  assign sda_oe_o = sda_q || ack_q;
  always @(negedge sda_i) if (scl_i) falls = 0;
  // Answer the ninth clock; held off the clock edge as a real slave would
  always @(negedge scl_i) begin
    falls = falls + 1;
    ack_q <= #120 (ack_en_i && falls == 9);
  end
  // Clock moves first, so data changes while the clock is high only when c is 1
  task automatic lines(input logic c, input logic d);
    scl_q = !c;
    repeat (2) @(posedge clk_sys_i);
    #2;
    sda_q = !d;
    repeat (4) @(posedge clk_sys_i);
    #2;
  endtask : lines
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      lines(1'b0, b[i]);
      lines(1'b1, b[i]);
    end
    lines(1'b0, 1'b1);
    lines(1'b1, 1'b1);
    ack = !sda_i;
    lines(1'b0, 1'b1);
  endtask : send_byte
endmodule : bus_partner

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic rst_i = 1'b1;
  logic controller_enable_i = 1'b0;
  logic initial_start_enable_i = 1'b0;
  logic reservation_disable_i = 1'b0;
  logic stop_interrupt_enable_i = 1'b0;
  logic [7:0] low_width_i = 8'h02;
  logic [7:0] high_width_i = 8'h02;
  logic [6:0] own_slave_address_i = 7'h2A;
  logic start_trigger_i = 1'b0;
  logic stop_trigger_i = 1'b0;
  logic exit_communication_i = 1'b0;
  logic shift_write_i = 1'b0;
  logic [7:0] shift_data_i = 8'h00;
  logic serial_clock_pin_i, serial_data_pin_i, serial_clock_pin_oe_o;
  logic serial_data_pin_oe_o, bus_busy_flag_o, master_status_flag_o;
  logic start_rejected_flag_o, reservation_pending_o, acknowledge_detected_o;
  logic extension_code_flag_o, address_match_flag_o, clock_level_flag_o;
  logic data_level_flag_o, serial_interrupt_o, p_scl, p_sda, got;
  logic [7:0] received_byte_o;
  logic ack_en = 1'b0;
  logic [16:0] lfsr = 17'h167C9;
  logic [15:0] obs;
  int checked = 0;
  int fail_count = 0;
  typedef struct {string nm; int lsb; logic [7:0] exp;} note_type;
  note_type q[$];
  event look;

  always #50 clk_sys_i = ~clk_sys_i;
  always #7.5 clk_link_i = ~clk_link_i;
  assign serial_clock_pin_i = !(serial_clock_pin_oe_o || p_scl);
  assign serial_data_pin_i = !(serial_data_pin_oe_o || p_sda);
  assign obs = {received_byte_o, serial_interrupt_o, serial_clock_pin_oe_o,
    extension_code_flag_o, acknowledge_detected_o, reservation_pending_o,
    start_rejected_flag_o, master_status_flag_o, bus_busy_flag_o};

  i2c_bus_start_stop_control uut (
    .clk_sys_i, .rst_i, .clk_link_i, .controller_enable_i,
    .initial_start_enable_i, .reservation_disable_i, .stop_interrupt_enable_i,
    .low_width_i, .high_width_i, .own_slave_address_i, .start_trigger_i,
    .stop_trigger_i, .exit_communication_i, .shift_write_i, .shift_data_i,
    .serial_clock_pin_i, .serial_data_pin_i, .serial_clock_pin_o(),
    .serial_clock_pin_oe_o, .serial_data_pin_o(), .serial_data_pin_oe_o,
    .bus_busy_flag_o, .master_status_flag_o, .start_rejected_flag_o,
    .reservation_pending_o, .acknowledge_detected_o, .extension_code_flag_o,
    .address_match_flag_o, .clock_level_flag_o, .data_level_flag_o,
    .received_byte_o, .serial_interrupt_o);
  bus_partner p (.clk_sys_i, .scl_i(serial_clock_pin_i),
    .sda_i(serial_data_pin_i), .ack_en_i(ack_en), .scl_oe_o(p_scl),
    .sda_oe_o(p_sda));

  function automatic logic [16:0] step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : step
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : tick
  task automatic check(input string nm, input logic [7:0] s,
    input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic note(input string nm, input int b, input logic [7:0] v);
    q.push_back('{nm, b, v});
    -> look;
    #1;
  endtask : note
  always @(look) begin
    note_type n;
    n = q.pop_front();
    check(n.nm, (n.lsb == 8) ? obs[15:8] : {7'h00, obs[n.lsb]}, n.exp);
  end
  // one trigger at a time, never rewritten while pending
  task automatic pulse(input int w);
    {start_trigger_i, stop_trigger_i, exit_communication_i,
      shift_write_i} = 4'h8 >> w;
    tick(1);
    {start_trigger_i, stop_trigger_i, exit_communication_i,
      shift_write_i} = 4'h0;
    tick(1);
  endtask : pulse
  task automatic wait_for(input int b, input logic v);
    for (int k = 0; obs[b] !== v; k++) begin
      if (k == 4000) begin
        check("wait", {7'h00, obs[b]}, {7'h00, v});
        results();
      end else tick(1);
    end
  endtask : wait_for

  initial begin
    lfsr = step(lfsr);
    low_width_i = {6'h00, lfsr[1:0]} + 8'h01;
    high_width_i = {6'h00, lfsr[3:2]} + 8'h01;
    // widths and address set before enable
    tick(6);
    rst_i = 1'b0;
    tick(3);
    // enable marks busy, stop frees the bus
    stop_interrupt_enable_i = 1'b1;
    controller_enable_i = 1'b1;
    tick(4);
    note("busy", 0, 8'h01);
    pulse(1);
    wait_for(0, 1'b0);
    $display("test busy on enable done");
    // option set treats a busy bus as free
    controller_enable_i = 1'b0;
    initial_start_enable_i = 1'b1;
    p.lines(1'b1, 1'b0);
    p.lines(1'b0, 1'b0);
    controller_enable_i = 1'b1;
    tick(4);
    note("busy", 0, 8'h00);
    p.lines(1'b1, 1'b0);
    p.lines(1'b1, 1'b1);
    check("lines high", {6'h00, clock_level_flag_o, data_level_flag_o},
      8'h03);
    $display("test free on enable done");
    // start on a free bus, one byte to a slave
    ack_en = 1'b1;
    pulse(0);
    note("master", 1, 8'h01);
    wait_for(6, 1'b1);
    tick(5);
    lfsr = step(lfsr);
    shift_data_i = lfsr[7:0];
    pulse(3);
    wait_for(7, 1'b1);
    tick(1);
    note("ack seen", 4, 8'h01);
    pulse(1);
    wait_for(0, 1'b0);
    ack_en = 1'b0;
    $display("test master byte done");
    // start refused on a busy bus
    controller_enable_i = 1'b0;
    initial_start_enable_i = 1'b0;
    reservation_disable_i = 1'b1;
    tick(2);
    controller_enable_i = 1'b1;
    tick(4);
    pulse(0);
    note("rejected", 2, 8'h01);
    note("master", 1, 8'h00);
    $display("test refused start done");
    // reservation launched by a stop, polled
    reservation_disable_i = 1'b0;
    stop_interrupt_enable_i = 1'b0;
    pulse(0);
    note("pending", 3, 8'h01);
    p.lines(1'b1, 1'b0);
    p.lines(1'b1, 1'b1);
    wait_for(1, 1'b1);
    wait_for(6, 1'b1);
    note("master", 1, 8'h01);
    // stays in the wait state with the clock held
    tick(4);
    note("held", 6, 8'h01);
    $display("test reservation done");
    // enabled inside a frame, extension code answered, exited
    controller_enable_i = 1'b0;
    initial_start_enable_i = 1'b1;
    tick(2);
    p.lines(1'b1, 1'b0);
    controller_enable_i = 1'b1;
    tick(2);
    lfsr = step(lfsr);
    shift_data_i = {i2c_ctl_pkg::EXT_CODE_PREFIX, lfsr[2:0]};
    p.send_byte(shift_data_i, got);
    check("ext ack", {7'h00, got}, 8'h01);
    note("ext flag", 5, 8'h01);
    note("byte", 8, shift_data_i);
    pulse(2);
    p.lines(1'b0, 1'b0);
    p.lines(1'b1, 1'b0);
    p.lines(1'b1, 1'b1);
    $display("test extension code done");
    results();
  end
endmodule : tb_top
